// [hw/acr_channel_regs.sv]
// register bank for channel 1 phase delay and channel 2 setup and gain
`timescale 1ns/1ps
`include "acr_params.svh"

module acr_channel_regs (
  input  wire logic       core_clk_in,
  input  wire logic       srst_in,
  input  wire logic [7:0] reg_addr_in,
  input  wire logic       reg_wr_in,
  input  wire logic [7:0] reg_wdata_in,
  input  wire logic       reg_rd_in,
  output logic [7:0]      reg_rdata_out,
  output logic            reg_rvalid_out,
  output logic            reg_unmapped_out,
  input  wire logic       mod_clk_en_in,
  input  wire logic       ch1_sample_in,
  output logic            ch1_sample_out,
  output logic            ch1_delay_busy_out,
  output logic [7:0]      ch1_phase_delay_cycles_out,
  input  wire logic [7:0] auto_gain_config_reg_in,
  output logic            ch2_input_kind_out,
  output logic [1:0]      ch2_input_source_out,
  output logic            ch2_coupling_select_out,
  output logic            ch2_swing_range_out,
  output logic [1:0]      ch2_amp_perf_mode_out,
  output logic            ch2_auto_gain_enable_out,
  output logic            ch2_auto_gain_mode_out,
  output logic [5:0]      ch2_analog_gain_db_out,
  output logic            ch2_config_fault_out
);

  acr_pkg::acr_bank_state_t st;
  acr_pkg::acr_bank_state_t next_st;

  // ----------------------------------------
  // address decode helpers
  // ----------------------------------------
  function automatic logic is_mapped(input logic [7:0] addr);
    is_mapped = (addr == `ACR_ADDR_PHASE) || (addr == `ACR_ADDR_SETUP) ||
                (addr == `ACR_ADDR_GAIN);
  endfunction : is_mapped

  function automatic logic [7:0] read_mux(input acr_pkg::acr_bank_state_t s,
                                          input logic [7:0]              addr);
    case (addr)
      `ACR_ADDR_PHASE: read_mux = s.phase;
      `ACR_ADDR_SETUP: read_mux = s.setup;
      `ACR_ADDR_GAIN:  read_mux = {s.gain[7:1], 1'b0};
      default:         read_mux = 8'h00;
    endcase
  endfunction : read_mux

  // ----------------------------------------
  // register update and read path
  // ----------------------------------------
  always_comb begin
    next_st          = st;
    next_st.rvalid   = 1'b0;
    next_st.unmapped = 1'b0;
    if (reg_wr_in) begin
      case (reg_addr_in)
        `ACR_ADDR_PHASE: next_st.phase = reg_wdata_in;
        `ACR_ADDR_SETUP: next_st.setup = reg_wdata_in;
        `ACR_ADDR_GAIN:  next_st.gain  = {reg_wdata_in[7:1], 1'b0};
        default:         next_st.unmapped = 1'b1;
      endcase
    end
    if (reg_rd_in) begin
      next_st.rvalid   = 1'b1;
      next_st.rdata    = read_mux(st, reg_addr_in);
      next_st.unmapped = !is_mapped(reg_addr_in);
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      st.phase    <= `ACR_RST_PHASE;
      st.setup    <= `ACR_RST_SETUP;
      st.gain     <= `ACR_RST_GAIN;
      st.rdata    <= 8'h00;
      st.rvalid   <= 1'b0;
      st.unmapped <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------
  // field outputs
  // ----------------------------------------
  logic [5:0] gain_field;
  logic [1:0] perf_field;
  logic [1:0] src_field;

  assign gain_field = st.gain[`ACR_GAIN_MSB:`ACR_GAIN_LSB];
  assign perf_field = st.setup[`ACR_PERF_MSB:`ACR_PERF_LSB];
  assign src_field  = st.setup[`ACR_SRC_MSB:`ACR_SRC_LSB];

  assign reg_rdata_out              = st.rdata;
  assign reg_rvalid_out             = st.rvalid;
  assign reg_unmapped_out           = st.unmapped;
  assign ch1_phase_delay_cycles_out = st.phase;
  assign ch2_input_kind_out         = st.setup[`ACR_KIND_BIT];
  assign ch2_input_source_out       = src_field;
  assign ch2_coupling_select_out    = st.setup[`ACR_COUPLE_BIT];
  assign ch2_swing_range_out        = st.setup[`ACR_SWING_BIT];
  // unusable modes fall back to high SNR
  assign ch2_amp_perf_mode_out      = (perf_field == `ACR_PERF_CMRR) ? `ACR_PERF_CMRR
                                                                    : `ACR_PERF_SNR;
  assign ch2_auto_gain_enable_out   = st.setup[`ACR_AGC_BIT];
  assign ch2_auto_gain_mode_out     = st.setup[`ACR_AGC_BIT] &
                                      auto_gain_config_reg_in[`ACR_AGC_MODE_BIT];
  // reserved gain codes saturate at the top step
  assign ch2_analog_gain_db_out     = (gain_field > `ACR_GAIN_MAX) ? `ACR_GAIN_MAX
                                                                   : gain_field;
  // flags programming that software must avoid
  assign ch2_config_fault_out       = (src_field > `ACR_SRC_SINGLE) ||
                                      (perf_field == 2'h1) || (perf_field == 2'h3) ||
                                      (gain_field > `ACR_GAIN_MAX) ||
                                      (st.setup[`ACR_AGC_BIT] &&
                                       st.setup[`ACR_COUPLE_BIT]);

  // ----------------------------------------
  // channel 1 phase delay
  // ----------------------------------------
  acr_phase_delay #(
    .WIDTH (`ACR_DELAY_WIDTH)
  ) u_phase_delay (
    .core_clk_in     (core_clk_in),
    .srst_in         (srst_in),
    .delay_cycles_in (st.phase),
    .mod_clk_en_in   (mod_clk_en_in),
    .sample_in       (ch1_sample_in),
    .sample_out      (ch1_sample_out),
    .busy_out        (ch1_delay_busy_out)
  );

  // ----------------------------------------
  // checks
  // ----------------------------------------
  property p_reset_values;
    @(posedge core_clk_in)
    srst_in |=> (st.phase == `ACR_RST_PHASE && st.setup == `ACR_RST_SETUP &&
                        st.gain == `ACR_RST_GAIN && ch2_coupling_select_out);
  endproperty
  a_reset_values: assert property (p_reset_values) else $error("reset value wrong");

  property p_setup_write;
    @(posedge core_clk_in) disable iff (srst_in)
    (reg_wr_in && reg_addr_in == `ACR_ADDR_SETUP) |=>
      (ch2_input_kind_out == $past(reg_wdata_in[7]) &&
       ch2_input_source_out == $past(reg_wdata_in[6:5]) &&
       ch2_coupling_select_out == $past(reg_wdata_in[4]) &&
       ch2_swing_range_out == $past(reg_wdata_in[3]) &&
       ch2_auto_gain_enable_out == $past(reg_wdata_in[0]));
  endproperty
  a_setup_write: assert property (p_setup_write) else $error("setup write lost");

  property p_phase_write;
    @(posedge core_clk_in) disable iff (srst_in)
    (reg_wr_in && reg_addr_in == `ACR_ADDR_PHASE) |=>
      ch1_phase_delay_cycles_out == $past(reg_wdata_in);
  endproperty
  a_phase_write: assert property (p_phase_write) else $error("phase write lost");

  property p_gain_ro_bit;
    @(posedge core_clk_in) disable iff (srst_in)
    (reg_rd_in && reg_addr_in == `ACR_ADDR_GAIN) |=>
      (reg_rvalid_out && reg_rdata_out[`ACR_GAIN_RO_BIT] == 1'b0);
  endproperty
  a_gain_ro_bit: assert property (p_gain_ro_bit) else $error("gain bit 0 not zero");

  property p_read_back;
    @(posedge core_clk_in) disable iff (srst_in)
    (reg_wr_in && reg_addr_in == `ACR_ADDR_SETUP) ##1
      (reg_rd_in && !reg_wr_in && reg_addr_in == `ACR_ADDR_SETUP) |=>
      reg_rdata_out == $past(reg_wdata_in, 2);
  endproperty
  a_read_back: assert property (p_read_back) else $error("read back mismatch");

  property p_gain_limit;
    @(posedge core_clk_in) disable iff (srst_in)
    ch2_analog_gain_db_out <= `ACR_GAIN_MAX;
  endproperty
  a_gain_limit: assert property (p_gain_limit) else $error("gain above top step");

  property p_auto_gain_mode;
    @(posedge core_clk_in) disable iff (srst_in)
    ch2_auto_gain_mode_out |-> (ch2_auto_gain_enable_out &&
                                auto_gain_config_reg_in[`ACR_AGC_MODE_BIT]);
  endproperty
  a_auto_gain_mode: assert property (p_auto_gain_mode) else $error("auto gain mode wrong");

  property p_perf_mode;
    @(posedge core_clk_in) disable iff (srst_in)
    (perf_field != `ACR_PERF_CMRR) |-> ch2_amp_perf_mode_out == `ACR_PERF_SNR;
  endproperty
  a_perf_mode: assert property (p_perf_mode) else $error("unusable mode reached");

  property p_dc_agc_fault;
    @(posedge core_clk_in) disable iff (srst_in)
    (ch2_auto_gain_enable_out && ch2_coupling_select_out) |-> ch2_config_fault_out;
  endproperty
  a_dc_agc_fault: assert property (p_dc_agc_fault) else $error("dc auto gain unflagged");

  property p_unmapped_read;
    @(posedge core_clk_in) disable iff (srst_in)
    (reg_rd_in && !(reg_addr_in inside {`ACR_ADDR_PHASE, `ACR_ADDR_SETUP, `ACR_ADDR_GAIN}))
      |=> (reg_rdata_out == 8'h00 && reg_unmapped_out);
  endproperty
  a_unmapped_read: assert property (p_unmapped_read) else $error("unmapped read wrong");

  property p_gain_write;
    @(posedge core_clk_in) disable iff (srst_in)
    (reg_wr_in && reg_addr_in == `ACR_ADDR_GAIN && reg_wdata_in[7:2] <= `ACR_GAIN_MAX) |=>
      ch2_analog_gain_db_out == $past(reg_wdata_in[`ACR_GAIN_MSB:`ACR_GAIN_LSB]);
  endproperty
  a_gain_write: assert property (p_gain_write) else $error("gain write lost");

  property p_gain_sat;
    @(posedge core_clk_in) disable iff (srst_in)
    (gain_field > `ACR_GAIN_MAX) |-> ch2_analog_gain_db_out == `ACR_GAIN_MAX;
  endproperty
  a_gain_sat: assert property (p_gain_sat) else $error("reserved gain not saturated");

  property p_gain_low_bits;
    @(posedge core_clk_in) disable iff (srst_in)
    (reg_wr_in && reg_addr_in == `ACR_ADDR_GAIN) |=>
      (st.gain[`ACR_GAIN_RSV_BIT] == $past(reg_wdata_in[`ACR_GAIN_RSV_BIT]) &&
       st.gain[`ACR_GAIN_RO_BIT] == 1'b0);
  endproperty
  a_gain_low_bits: assert property (p_gain_low_bits) else $error("gain low bits wrong");

  property p_rvalid_pulse;
    @(posedge core_clk_in) disable iff (srst_in)
    reg_rd_in |=> reg_rvalid_out;
  endproperty
  a_rvalid_pulse: assert property (p_rvalid_pulse) else $error("read not answered");

  property p_rvalid_idle;
    @(posedge core_clk_in) disable iff (srst_in)
    !reg_rd_in |=> !reg_rvalid_out;
  endproperty
  a_rvalid_idle: assert property (p_rvalid_idle) else $error("read valid without read");

  property p_rdata_hold;
    @(posedge core_clk_in) disable iff (srst_in)
    !reg_rd_in |=> $stable(reg_rdata_out);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");

  property p_unmapped_write;
    @(posedge core_clk_in) disable iff (srst_in)
    (reg_wr_in && !reg_rd_in &&
     !(reg_addr_in inside {`ACR_ADDR_PHASE, `ACR_ADDR_SETUP, `ACR_ADDR_GAIN})) |=>
      (reg_unmapped_out && $stable(st.phase) && $stable(st.setup) && $stable(st.gain));
  endproperty
  a_unmapped_write: assert property (p_unmapped_write) else $error("unmapped write landed");

  // ----------------------------------------
  // hold, fault, auto gain mode and sample strobe checks
  // ----------------------------------------
  property p_phase_hold;
    @(posedge core_clk_in) disable iff (srst_in)
    !(reg_wr_in && reg_addr_in == `ACR_ADDR_PHASE) |=> $stable(st.phase);
  endproperty
  a_phase_hold: assert property (p_phase_hold) else $error("phase changed unwritten");

  property p_setup_hold;
    @(posedge core_clk_in) disable iff (srst_in)
    !(reg_wr_in && reg_addr_in == `ACR_ADDR_SETUP) |=> $stable(st.setup);
  endproperty
  a_setup_hold: assert property (p_setup_hold) else $error("setup changed unwritten");

  property p_gain_hold;
    @(posedge core_clk_in) disable iff (srst_in)
    !(reg_wr_in && reg_addr_in == `ACR_ADDR_GAIN) |=> $stable(st.gain);
  endproperty
  a_gain_hold: assert property (p_gain_hold) else $error("gain changed unwritten");

  property p_src_fault;
    @(posedge core_clk_in) disable iff (srst_in)
    (src_field > `ACR_SRC_SINGLE) |-> ch2_config_fault_out;
  endproperty
  a_src_fault: assert property (p_src_fault) else $error("reserved source unflagged");

  property p_perf_fault;
    @(posedge core_clk_in) disable iff (srst_in)
    perf_field[0] |-> ch2_config_fault_out;
  endproperty
  a_perf_fault: assert property (p_perf_fault) else $error("unusable mode unflagged");

  property p_gain_fault;
    @(posedge core_clk_in) disable iff (srst_in)
    (gain_field > `ACR_GAIN_MAX) |-> ch2_config_fault_out;
  endproperty
  a_gain_fault: assert property (p_gain_fault) else $error("reserved gain unflagged");

  property p_fault_clear;
    @(posedge core_clk_in) disable iff (srst_in)
    (!(ch2_auto_gain_enable_out && ch2_coupling_select_out) &&
     src_field <= `ACR_SRC_SINGLE && !perf_field[0] && gain_field <= `ACR_GAIN_MAX)
      |-> !ch2_config_fault_out;
  endproperty
  a_fault_clear: assert property (p_fault_clear) else $error("fault without cause");

  property p_mode_follow;
    @(posedge core_clk_in) disable iff (srst_in)
    (ch2_auto_gain_enable_out && auto_gain_config_reg_in[`ACR_AGC_MODE_BIT])
      |-> ch2_auto_gain_mode_out;
  endproperty
  a_mode_follow: assert property (p_mode_follow) else $error("auto gain mode missing");

  property p_sample_idle;
    @(posedge core_clk_in) disable iff (srst_in)
    ch1_sample_out |-> !ch1_delay_busy_out;
  endproperty
  a_sample_idle: assert property (p_sample_idle) else $error("busy with sample out");

endmodule : acr_channel_regs

// [hw/acr_phase_delay.sv]
// sample strobe delay counted in modulator clock cycles
`timescale 1ns/1ps
`include "acr_params.svh"

module acr_phase_delay #(
  parameter int WIDTH = `ACR_DELAY_WIDTH
) (
  input  wire logic             core_clk_in,
  input  wire logic             srst_in,
  input  wire logic [WIDTH-1:0] delay_cycles_in,
  input  wire logic             mod_clk_en_in,
  input  wire logic             sample_in,
  output logic                  sample_out,
  output logic                  busy_out
);

  acr_pkg::acr_delay_state_t st;
  acr_pkg::acr_delay_state_t next_st;

  // ----------------------------------------
  // delay counter
  // ----------------------------------------
  always_comb begin
    next_st = st;
    next_st.pulse = 1'b0;
    if (sample_in) begin
      if (delay_cycles_in == '0) begin
        next_st.pulse = 1'b1;
        next_st.busy  = 1'b0;
      end else begin
        next_st.count = 8'(delay_cycles_in);
        next_st.busy  = 1'b1;
      end
    end else if (st.busy && mod_clk_en_in) begin
      next_st.count = st.count - 8'h01;
      if (st.count == 8'h01) begin
        next_st.pulse = 1'b1;
        next_st.busy  = 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign sample_out = st.pulse;
  assign busy_out   = st.busy;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  property p_zero_delay;
    @(posedge core_clk_in) disable iff (srst_in)
    (sample_in && delay_cycles_in == '0) |=> sample_out;
  endproperty
  a_zero_delay: assert property (p_zero_delay) else $error("zero delay not immediate");

  property p_no_early;
    @(posedge core_clk_in) disable iff (srst_in)
    (busy_out && st.count > 8'h01 && !sample_in) |=> !sample_out;
  endproperty
  a_no_early: assert property (p_no_early) else $error("delayed sample too early");

  property p_one_cycle;
    @(posedge core_clk_in) disable iff (srst_in)
    (sample_in && delay_cycles_in == 8'h01) ##1 (!sample_in)[*1] ##0 mod_clk_en_in
      |=> sample_out;
  endproperty
  a_one_cycle: assert property (p_one_cycle) else $error("one cycle delay wrong");

endmodule : acr_phase_delay

// [shared/acr_params.svh]
// constants for the channel configuration register bank
// Operation
// - channel 1 delay equals field in modulator cycles
// - setup bit 7: microphone or line input
// - bits 6-5: differential, single-ended; 2,3 reserved
// - bit 4 coupling, resets to DC-coupled
// - bit 3 swing range, low swing at reset
// - bits 2-1 performance mode; 1 and 3 unusable
// - bit 0 enables auto gain, mode from auto gain config bit 3
// - gain bits 7-2, 0 to 42 dB, above reserved
// - offsets 0x40, 0x41, 0x42; resets 0x00, 0x10, 0x00
`ifndef ACR_PARAMS_SVH
`define ACR_PARAMS_SVH

// ----------------------------------------
// offsets and reset values
// ----------------------------------------
`define ACR_ADDR_PHASE      8'h40
`define ACR_ADDR_SETUP      8'h41
`define ACR_ADDR_GAIN       8'h42
`define ACR_RST_PHASE       8'h00
`define ACR_RST_SETUP       8'h10
`define ACR_RST_GAIN        8'h00

// ----------------------------------------
// field positions
// ----------------------------------------
`define ACR_KIND_BIT        7
`define ACR_SRC_MSB         6
`define ACR_SRC_LSB         5
`define ACR_COUPLE_BIT      4
`define ACR_SWING_BIT       3
`define ACR_PERF_MSB        2
`define ACR_PERF_LSB        1
`define ACR_AGC_BIT         0
`define ACR_GAIN_MSB        7
`define ACR_GAIN_LSB        2
`define ACR_GAIN_RSV_BIT    1
`define ACR_GAIN_RO_BIT     0
`define ACR_AGC_MODE_BIT    3

// ----------------------------------------
// codes and limits
// ----------------------------------------
`define ACR_SRC_DIFF        2'h0
`define ACR_SRC_SINGLE      2'h1
`define ACR_PERF_SNR        2'h0
`define ACR_PERF_CMRR       2'h2
`define ACR_GAIN_MAX        6'h2A
`define ACR_DELAY_WIDTH     8

`endif

// [shared/acr_pkg.sv]
// types of the channel configuration register bank
package acr_pkg;

  // ----------------------------------------
  // register bank state
  // ----------------------------------------
  typedef struct packed {
    logic [7:0] phase;
    logic [7:0] setup;
    logic [7:0] gain;
    logic [7:0] rdata;
    logic       rvalid;
    logic       unmapped;
  } acr_bank_state_t;

  // ----------------------------------------
  // phase delay state
  // ----------------------------------------
  typedef struct packed {
    logic [7:0] count;
    logic       busy;
    logic       pulse;
  } acr_delay_state_t;

endpackage : acr_pkg

// [testbench/tb_top.sv]
// self-checking bench for the channel configuration register bank
`timescale 1ns/1ps
`include "acr_params.svh"

module tb_top;
  // ----------------------------------------
  // stimulus and observed signals
  // ----------------------------------------
  logic       core_clk_in             = 1'b0;
  logic       srst_in                 = 1'b1;
  logic [7:0] reg_addr_in             = 8'h00;
  logic       reg_wr_in               = 1'b0;
  logic [7:0] reg_wdata_in            = 8'h00;
  logic       reg_rd_in               = 1'b0;
  logic       mod_clk_en_in           = 1'b0;
  logic       ch1_sample_in           = 1'b0;
  logic [7:0] auto_gain_config_reg_in = 8'h00;
  logic [7:0] reg_rdata_out;
  logic       reg_rvalid_out;
  logic       reg_unmapped_out;
  logic       ch1_sample_out;
  logic       ch1_delay_busy_out;
  logic [7:0] ch1_phase_delay_cycles_out;
  logic       ch2_input_kind_out;
  logic [1:0] ch2_input_source_out;
  logic       ch2_coupling_select_out;
  logic       ch2_swing_range_out;
  logic [1:0] ch2_amp_perf_mode_out;
  logic       ch2_auto_gain_enable_out;
  logic       ch2_auto_gain_mode_out;
  logic [5:0] ch2_analog_gain_db_out;
  logic       ch2_config_fault_out;
  int          n_mismatch = 0;
  int          checks     = 0;
  int          cycles     = 0;
  logic [31:0] seed       = 32'h8E4EEF9A;
  logic [7:0]  exp_q[$];
  logic [7:0]  phase_m = `ACR_RST_PHASE;
  logic [7:0]  setup_m = `ACR_RST_SETUP;
  logic [7:0]  gain_m  = `ACR_RST_GAIN;
  logic [5:0]  gtab [4] = '{6'h2A, 6'h2B, 6'h3F, 6'h00};
  int          dtab [4] = '{0, 1, 2, 255};

  always #50 core_clk_in = ~core_clk_in;

  acr_channel_regs dut (.core_clk_in(core_clk_in), .srst_in(srst_in),
    .reg_addr_in(reg_addr_in), .reg_wr_in(reg_wr_in), .reg_wdata_in(reg_wdata_in),
    .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .reg_rvalid_out(reg_rvalid_out),
    .reg_unmapped_out(reg_unmapped_out), .mod_clk_en_in(mod_clk_en_in),
    .ch1_sample_in(ch1_sample_in), .ch1_sample_out(ch1_sample_out),
    .ch1_delay_busy_out(ch1_delay_busy_out),
    .ch1_phase_delay_cycles_out(ch1_phase_delay_cycles_out),
    .auto_gain_config_reg_in(auto_gain_config_reg_in),
    .ch2_input_kind_out(ch2_input_kind_out), .ch2_input_source_out(ch2_input_source_out),
    .ch2_coupling_select_out(ch2_coupling_select_out),
    .ch2_swing_range_out(ch2_swing_range_out), .ch2_amp_perf_mode_out(ch2_amp_perf_mode_out),
    .ch2_auto_gain_enable_out(ch2_auto_gain_enable_out),
    .ch2_auto_gain_mode_out(ch2_auto_gain_mode_out),
    .ch2_analog_gain_db_out(ch2_analog_gain_db_out),
    .ch2_config_fault_out(ch2_config_fault_out));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [31:0] rand32();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rand32

  task automatic report_and_stop();
    $display("mismatches %0d checks %0d", n_mismatch, checks);
    if (n_mismatch == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : report_and_stop

  task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %0h seen %0h", name, exp, seen);
    end
  endtask : check

  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(negedge core_clk_in);
    reg_addr_in  = a;
    reg_wdata_in = d;
    reg_wr_in    = 1'b1;
    @(negedge core_clk_in);
    reg_wr_in = 1'b0;
    if (a == `ACR_ADDR_PHASE) phase_m = d;
    if (a == `ACR_ADDR_SETUP) setup_m = d;
    if (a == `ACR_ADDR_GAIN) gain_m = {d[7:1], 1'b0};
    check("unmapped", reg_unmapped_out, (a < 8'h40) || (a > 8'h42));
  endtask : wr

  task automatic rd(logic [7:0] a);
    @(negedge core_clk_in);
    reg_addr_in = a;
    reg_rd_in   = 1'b1;
    case (a)
      `ACR_ADDR_PHASE: exp_q.push_back(phase_m);
      `ACR_ADDR_SETUP: exp_q.push_back(setup_m);
      `ACR_ADDR_GAIN:  exp_q.push_back(gain_m);
      default:         exp_q.push_back(8'h00);
    endcase
    @(negedge core_clk_in);
    reg_rd_in = 1'b0;
    check("rd_unmapped", reg_unmapped_out, (a < 8'h40) || (a > 8'h42));
  endtask : rd

  task automatic check_fields();
    logic [1:0] p;
    p = setup_m[2:1];
    check("kind", ch2_input_kind_out, setup_m[7]);
    check("source", ch2_input_source_out, setup_m[6:5]);
    check("coupling", ch2_coupling_select_out, setup_m[4]);
    check("swing", ch2_swing_range_out, setup_m[3]);
    check("perf", ch2_amp_perf_mode_out, (p == 2'h2) ? 2'h2 : 2'h0);
    check("agc_en", ch2_auto_gain_enable_out, setup_m[0]);
    check("agc_mode", ch2_auto_gain_mode_out, setup_m[0] & auto_gain_config_reg_in[3]);
    check("gain_db", ch2_analog_gain_db_out, (gain_m[7:2] > 6'h2A) ? 6'h2A : gain_m[7:2]);
    check("fault", ch2_config_fault_out, (setup_m[6:5] > 2'h1) || p[0] ||
          (gain_m[7:2] > 6'h2A) || (setup_m[0] && setup_m[4]));
    check("phase", ch1_phase_delay_cycles_out, phase_m);
  endtask : check_fields

  task automatic delay_run(int n);
    int e;
    e = (n == 0) ? 1 : n + 1;
    @(negedge core_clk_in);
    ch1_sample_in = 1'b1;
    for (int k = 1; k <= e + 1; k++) begin
      @(negedge core_clk_in);
      ch1_sample_in = 1'b0;
      mod_clk_en_in = (k >= 1) && (k <= n);
      check("sample", ch1_sample_out, k == e);
      check("busy", ch1_delay_busy_out, (k < e) && (n != 0));
    end
  endtask : delay_run

  // ----------------------------------------
  // read data monitor and timeout
  // ----------------------------------------
  always @(negedge core_clk_in) begin
    if (reg_rvalid_out === 1'b1) begin
      if (exp_q.size() == 0) check("spurious_rvalid", 1, 0);
      else check("rdata", reg_rdata_out, exp_q.pop_front());
    end
  end

  always @(posedge core_clk_in) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      $display("ERROR timeout after %0d cycles", cycles);
      report_and_stop();
    end
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    logic [31:0] r;
    repeat (20) @(negedge core_clk_in);
    srst_in = 1'b0;
    check_fields();
    rd(`ACR_ADDR_PHASE);
    rd(`ACR_ADDR_SETUP);
    rd(`ACR_ADDR_GAIN);
    for (int i = 0; i < 4; i++) begin
      wr(`ACR_ADDR_SETUP, {1'b0, 2'(i), 2'b00, 2'(i), 1'b0});
      check_fields();
    end
    foreach (gtab[i]) begin
      wr(`ACR_ADDR_GAIN, {gtab[i], 2'b11});
      check_fields();
      rd(`ACR_ADDR_GAIN);
    end
    wr(`ACR_ADDR_SETUP, 8'h08);
    wr(`ACR_ADDR_GAIN, 8'h00);
    check_fields();
    @(negedge core_clk_in);
    reg_addr_in  = `ACR_ADDR_SETUP;
    reg_wdata_in = 8'h21;
    reg_wr_in    = 1'b1;
    @(negedge core_clk_in);
    reg_wr_in = 1'b0;
    reg_rd_in = 1'b1;
    setup_m   = 8'h21;
    exp_q.push_back(setup_m);
    @(negedge core_clk_in);
    reg_rd_in = 1'b0;
    check_fields();
    for (int i = 0; i < 40; i++) begin
      r = rand32();
      auto_gain_config_reg_in = r[31:24];
      wr(8'h40 + {6'h00, r[1:0]}, r[15:8]);
      check_fields();
      rd(8'h40 + {6'h00, r[3:2]});
    end
    wr(8'h00, 8'hFF);
    rd(8'h00);
    foreach (dtab[i]) begin
      wr(`ACR_ADDR_PHASE, 8'(dtab[i]));
      delay_run(dtab[i]);
    end
    wr(`ACR_ADDR_SETUP, 8'hEF);
    srst_in = 1'b1;
    repeat (3) @(negedge core_clk_in);
    srst_in = 1'b0;
    phase_m = `ACR_RST_PHASE;
    setup_m = `ACR_RST_SETUP;
    gain_m  = `ACR_RST_GAIN;
    check_fields();
    rd(`ACR_ADDR_SETUP);
    repeat (3) @(negedge core_clk_in);
    check("pending", exp_q.size(), 0);
    report_and_stop();
  end
endmodule : tb_top
